// File: hw/dccp_core.sv
`timescale 1ns/1ps

module dccp_core
    import dccp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_pa_sck,
    input wire logic i_chip_select_n,
    input wire logic i_pa_mosi,
    output logic o_pa_miso,
    output logic o_pa_tx_pulse,
    output logic o_pb_sck,
    output logic o_pb_chip_select_n,
    output logic o_pb_mosi,
    input wire logic i_pb_miso,
    input wire logic i_isolated_mode_select,
    input wire logic i_conv_busy,
    output logic o_conv_start,
    input wire logic [DATA_W-1:0] i_rd_data,
    output logic [DATA_W-1:0] o_wr_data,
    output logic o_wr_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // Link domain, clocked by the host-facing serial clock

    logic frame_rst, lnk_rst;
    logic [7:0] bit_cnt_q;
    logic [15:0] cmd_sr_q, exp_word;
    logic [14:0] crc_q;
    logic pec_err_q, exp_bit, cmd_done;
    logic [10:0] cmd_code;
    dccp_mode_type mode_q;
    logic conv_req_q, miso_q;
    logic [FRAME_W-2:0] rd_sr_q;
    logic [FRAME_W-1:0] wr_sr_q;
    logic wr_full_q, lnk_busy;
    logic bsy_s1_q, bsy_s2_q, ack_s1_q, ack_s2_q, iso_s1_q, iso_s2_q;
    logic tx_set_q, tx_clr_q;

    // Sys domain state read by the link side while it is stable
    logic [DATA_W-1:0] rd_hold_q;
    logic [15:0] rd_pec_q;
    logic busy_q, ack_p_q, ack_q;

    // Chip select high ends every frame without needing a clock edge
    assign frame_rst = i_chip_select_n | ~i_rst_n;
    assign lnk_rst = ~i_rst_n;

    // Expected error code bit during the third and fourth command bytes
    assign exp_word = {crc_q, 1'b0};
    assign exp_bit = exp_word[~bit_cnt_q[3:0]];
    assign cmd_code = cmd_sr_q[10:0];

    // Command accepted on its last bit when its top five bits are zero and code and error code agree
    assign cmd_done = (bit_cnt_q == CMD_LAST) && !pec_err_q && (i_pa_mosi == exp_bit)
        && (cmd_sr_q[15:11] == CMD_HI_ZERO);

    // Own busy merged with the not yet acknowledged start request
    assign lnk_busy = bsy_s2_q | (conv_req_q != ack_s2_q);

    // Serial bit counter, saturating for long chains
    always_ff @(posedge i_pa_sck or posedge frame_rst)
    begin
        if (frame_rst)
            bit_cnt_q <= 8'h00;
        else if (bit_cnt_q != CNT_MAX)
            bit_cnt_q <= bit_cnt_q + 8'h01;
    end

    // Command capture and its running error code over all 16 bits
    always_ff @(posedge i_pa_sck or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            cmd_sr_q <= 16'h0000;
            crc_q <= PEC_SEED;
        end
        else if (bit_cnt_q < CMD_BITS)
        begin
            cmd_sr_q <= {cmd_sr_q[14:0], i_pa_mosi};
            crc_q <= pec_step(crc_q, i_pa_mosi);
        end
    end

    // Any mismatching error code bit spoils the command
    always_ff @(posedge i_pa_sck or posedge frame_rst)
    begin
        if (frame_rst)
            pec_err_q <= 1'b0;
        else if (bit_cnt_q >= CMD_BITS && bit_cnt_q < CMD_LAST && i_pa_mosi != exp_bit)
            pec_err_q <= 1'b1;
    end

    // Frame mode chosen once the four command bytes are in
    always_ff @(posedge i_pa_sck or posedge frame_rst)
    begin
        if (frame_rst)
            mode_q <= M_CMD;
        else if (bit_cnt_q == CMD_LAST)
        begin
            if (!cmd_done)
                mode_q <= M_IGNORE;
            else if (is_write(cmd_code))
                mode_q <= M_WRITE;
            else if (is_read(cmd_code))
                mode_q <= M_READ;
            else if (is_conv(cmd_code) || cmd_code == CODE_POLL)
                mode_q <= M_POLL;
            else
                mode_q <= M_IGNORE;
        end
    end

    // Start request toggles across to the system clock
    always_ff @(posedge i_pa_sck or posedge lnk_rst)
    begin
        if (lnk_rst)
            conv_req_q <= 1'b0;
        else if (cmd_done && is_conv(cmd_code))
            conv_req_q <= ~conv_req_q;
    end

    // Serial output; idles high and goes high the moment select rises
    always_ff @(posedge i_pa_sck or posedge frame_rst)
    begin
        if (frame_rst)
            miso_q <= 1'b1;
        else if (cmd_done && is_read(cmd_code))
            miso_q <= rd_hold_q[DATA_W-1];
        else if (bit_cnt_q == CMD_LAST)
            miso_q <= ~cmd_done | is_write(cmd_code) | ~(is_conv(cmd_code)
                | (cmd_code == CODE_POLL));
        else
        begin
            case (mode_q)
                M_READ: miso_q <= rd_sr_q[FRAME_W-2];
                M_POLL: miso_q <= i_pb_miso & ~lnk_busy;
                default: miso_q <= 1'b1;
            endcase
        end
    end

    // Read chain: own payload, then upper port bits 64 clocks later
    always_ff @(posedge i_pa_sck or posedge lnk_rst)
    begin
        if (lnk_rst)
            rd_sr_q <= '0;
        else if (cmd_done && is_read(cmd_code))
            rd_sr_q <= {rd_hold_q[DATA_W-2:0], rd_pec_q};
        else if (mode_q == M_READ)
            rd_sr_q <= {rd_sr_q[FRAME_W-3:0], i_pb_miso};
    end

    // Write chain; kept across select high so the sys side can copy it
    always_ff @(posedge i_pa_sck or posedge lnk_rst)
    begin
        if (lnk_rst)
            wr_sr_q <= '0;
        else if (mode_q == M_WRITE)
            wr_sr_q <= {wr_sr_q[FRAME_W-2:0], i_pa_mosi};
    end

    // Marks a complete own payload; cleared on the next frame's first edge
    always_ff @(posedge i_pa_sck or posedge lnk_rst)
    begin
        if (lnk_rst)
            wr_full_q <= 1'b0;
        else if (bit_cnt_q == 8'h00)
            wr_full_q <= 1'b0;
        else if (mode_q == M_WRITE && bit_cnt_q == WR_FULL)
            wr_full_q <= 1'b1;
    end

    // Synchronisers into the link domain
    always_ff @(posedge i_pa_sck or posedge lnk_rst)
    begin
        if (lnk_rst)
        begin
            bsy_s1_q <= 1'b0;
            bsy_s2_q <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            iso_s1_q <= 1'b0;
            iso_s2_q <= 1'b0;
        end
        else
        begin
            bsy_s1_q <= busy_q;
            bsy_s2_q <= bsy_s1_q;
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
            iso_s1_q <= i_isolated_mode_select;
            iso_s2_q <= iso_s1_q;
        end
    end

    // Answer pulse opens on a received master pulse, closes half a clock on
    always_ff @(posedge i_pa_sck or posedge frame_rst)
    begin
        if (frame_rst)
            tx_set_q <= 1'b0;
        else if (mode_q == M_READ || mode_q == M_POLL)
            tx_set_q <= ~tx_set_q;
    end

    always_ff @(negedge i_pa_sck or posedge frame_rst)
    begin
        if (frame_rst)
            tx_clr_q <= 1'b0;
        else
            tx_clr_q <= tx_set_q;
    end

    // Isolated mode only ever answers; plain serial drives continuously
    assign o_pa_tx_pulse = iso_s2_q & (tx_set_q ^ tx_clr_q);
    assign o_pa_miso = miso_q;

    // Commands pass straight up so the whole stack sees them together
    assign o_pb_mosi = (mode_q == M_WRITE) ? wr_sr_q[FRAME_W-1] : i_pa_mosi;
    assign o_pb_sck = i_pa_sck;
    assign o_pb_chip_select_n = i_chip_select_n;

    ////////////////////////////////////////////////////////////////////////////
    // System domain

    logic cs_s1_q, cs_s2_q, cs_s3_q;
    logic req_s1_q, req_s2_q, req_s3_q;
    logic pend_q, conv_start_q;
    logic start_seen, cs_rise;

    assign start_seen = req_s2_q ^ req_s3_q;
    assign cs_rise = cs_s2_q & ~cs_s3_q;

    // Select and start request synchronisers
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
            ack_p_q <= 1'b0;
            ack_q <= 1'b0;
        end
        else
        begin
            cs_s1_q <= i_chip_select_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            req_s1_q <= conv_req_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            ack_p_q <= req_s3_q; // Trails busy so the link never sees a false idle
            ack_q <= ack_p_q;
        end
    end

    // Busy covers the gap until the converter itself reports busy
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            pend_q <= 1'b0;
            conv_start_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            pend_q <= start_seen | (pend_q & ~i_conv_busy);
            conv_start_q <= start_seen;
            busy_q <= pend_q | i_conv_busy;
        end
    end

    // Read snapshot only moves while select is high, so the link reads it stable
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            rd_hold_q <= '0;
            rd_pec_q <= 16'h0000;
        end
        else if (cs_s2_q)
        begin
            rd_hold_q <= i_rd_data;
            rd_pec_q <= pec_word(i_rd_data);
        end
    end

    // Write payload copied once the link clock has stopped after the frame
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rst_n)
        begin
            o_wr_data <= '0;
            o_wr_valid <= 1'b0;
        end
        else
        begin
            o_wr_valid <= 1'b0;
            if (cs_rise && wr_full_q && pec_word(wr_sr_q[FRAME_W-1:16]) == wr_sr_q[15:0])
            begin
                o_wr_data <= wr_sr_q[FRAME_W-1:16];
                o_wr_valid <= 1'b1;
            end
        end
    end

    assign o_conv_start = conv_start_q;

endmodule

// File: hw/dccp_pkg.sv
package dccp_pkg;

    // Payload geometry of one stacked device
    localparam int PAYLOAD_BYTES = 6;
    localparam int DATA_W = PAYLOAD_BYTES * 8;
    localparam int FRAME_W = DATA_W + 16;

    // Serial bit counts within a frame
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CMD_BITS = 8'h10;
    localparam logic [7:0] CMD_LAST = 8'h1f;
    localparam logic [7:0] WR_FULL = 8'h5f;
    localparam logic [4:0] CMD_HI_ZERO = 5'h00;

    // Error code generator, shared with the controller
    localparam logic [14:0] PEC_POLY = 15'h4c11;
    localparam logic [14:0] PEC_SEED = 15'h0001;

    // Command codes
    localparam logic [10:0] CODE_POLL = 11'h714;

    typedef enum logic [2:0] {M_CMD, M_WRITE, M_READ, M_POLL, M_IGNORE} dccp_mode_type;

    // One serial step of the error code generator
    function automatic logic [14:0] pec_step(input logic [14:0] crc, input logic din);
        logic fb;
        fb = din ^ crc[14];
        pec_step = {crc[13:0], 1'b0} ^ (fb ? PEC_POLY : 15'h0000);
    endfunction

    // Error code of a payload, MSB first, zero appended
    function automatic logic [15:0] pec_word(input logic [DATA_W-1:0] data);
        logic [14:0] crc;
        crc = PEC_SEED;
        for (int i = DATA_W - 1; i >= 0; i--)
        begin
            crc = pec_step(crc, data[i]);
        end
        pec_word = {crc, 1'b0};
    endfunction

    function automatic logic is_write(input logic [10:0] code);
        case (code)
            11'h001, 11'h024, 11'h014, 11'h020, 11'h01c, 11'h721: is_write = 1'b1;
            default: is_write = 1'b0;
        endcase
    endfunction

    function automatic logic is_read(input logic [10:0] code);
        case (code)
            11'h002, 11'h026, 11'h004, 11'h006, 11'h008, 11'h00a,
            11'h009, 11'h00b, 11'h00c, 11'h00e, 11'h00d, 11'h00f,
            11'h010, 11'h012, 11'h016, 11'h022, 11'h01e, 11'h722: is_read = 1'b1;
            default: is_read = 1'b0;
        endcase
    endfunction

    // Conversion starts occupy the 01 and 10 code spaces
    function automatic logic is_conv(input logic [10:0] code);
        is_conv = code[10] ^ code[9];
    endfunction

endpackage

// File: sim/dccp_core_asserts.sv
`timescale 1ns/1ps
module dccp_core_asserts
    import dccp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_pa_sck,
    input wire logic i_chip_select_n,
    input wire logic i_pa_mosi,
    input wire logic o_pa_miso,
    input wire logic o_pa_tx_pulse,
    input wire logic o_pb_sck,
    input wire logic o_pb_chip_select_n,
    input wire logic o_pb_mosi,
    input wire logic i_pb_miso,
    input wire logic i_isolated_mode_select,
    input wire logic i_conv_busy,
    input wire logic o_conv_start,
    input wire logic [DATA_W-1:0] i_rd_data,
    input wire logic [DATA_W-1:0] o_wr_data,
    input wire logic o_wr_valid
);
    logic [7:0] cnt_q;

    // Link edge count; select high clears it, as it ends the frame
    always_ff @(posedge i_pa_sck or posedge i_chip_select_n or negedge i_rst_n)
    begin
        if (!i_rst_n || i_chip_select_n)
            cnt_q <= 8'h00;
        else if (cnt_q != 8'hff)
            cnt_q <= cnt_q + 8'h01;
    end

    ////////////////////////////////////////
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    // Pulse falls back on the next cycle
    sequence s_low_next(logic s);
        ##1 !s;
    endsequence

    AST_IDLE_HIGH: assert property (i_chip_select_n && $past(i_chip_select_n) |-> o_pa_miso)
        else $error("serial out low while deselected");
    AST_PB_COPY: assert property (o_pb_sck == i_pa_sck && o_pb_chip_select_n == i_chip_select_n)
        else $error("upper port clock or select not passed on");
    AST_PB_CMD: assert property (!i_chip_select_n && cnt_q < 8'h20 |-> o_pb_mosi == i_pa_mosi)
        else $error("command bits not passed upward");
    AST_CMD_QUIET: assert property (!i_chip_select_n && cnt_q < 8'h20 |-> o_pa_miso)
        else $error("serial out moved before command end");
    AST_TX_SCK: assert property (o_pa_tx_pulse |-> i_pa_sck && cnt_q >= 8'h20)
        else $error("answer pulse without master pulse");
    AST_CONV_ONE: assert property (o_conv_start |-> s_low_next(o_conv_start))
        else $error("conversion start longer than one cycle");
    AST_WR_ONE: assert property (o_wr_valid |-> s_low_next(o_wr_valid))
        else $error("write strobe longer than one cycle");
    AST_WR_CLOSED: assert property (o_wr_valid |-> i_chip_select_n && $past(i_chip_select_n, 2))
        else $error("write payload taken before frame end");
endmodule

bind dccp_core dccp_core_asserts u_chk (.i_sys_clk, .i_rst_n, .i_pa_sck, .i_chip_select_n,
    .i_pa_mosi, .o_pa_miso, .o_pa_tx_pulse, .o_pb_sck, .o_pb_chip_select_n, .o_pb_mosi,
    .i_pb_miso, .i_isolated_mode_select, .i_conv_busy, .o_conv_start, .i_rd_data,
    .o_wr_data, .o_wr_valid);

// File: sim/dccp_upper_model.sv
`timescale 1ns/1ps
// Upper stacked device, status answer only; high while deselected
module dccp_upper_model
(
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_busy,
    output logic o_miso
);
    logic [7:0] n_q;

    // Own zero after the command, then status on every clock
    always @(posedge i_sck or posedge i_cs_n)
    begin
        if (i_cs_n)
        begin
            n_q <= 8'h00;
            o_miso <= 1'b1;
        end
        else
        begin
            n_q <= n_q + 8'h01;
            if (n_q == 8'h1f)
                o_miso <= 1'b0;
            else if (n_q > 8'h1f)
                o_miso <= ~i_busy;
        end
    end
endmodule

// File: sim/dccp_core_tb.sv
`timescale 1ns/1ps
module dccp_core_tb import dccp_pkg::*;;
    logic i_sys_clk = 0, i_rst_n = 0, sck = 0, cs_n = 1, mosi = 0;
    logic iso = 0, busy = 0, up_busy = 0, pb_miso, miso, txp, conv, wr_valid, tx_seen;
    logic pb_sck, pb_cs_n, pb_mosi;
    logic [DATA_W-1:0] rd_data = '0, wr_data, wr_got;
    logic [159:0] rx, rxp;
    int failures = 0, num_checks = 0, cycles = 0, starts = 0, wrs = 0;

    initial forever #2.5 i_sys_clk = ~i_sys_clk;

    dccp_core dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_pa_sck(sck),
        .i_chip_select_n(cs_n), .i_pa_mosi(mosi), .o_pa_miso(miso), .o_pa_tx_pulse(txp),
        .o_pb_sck(pb_sck), .o_pb_chip_select_n(pb_cs_n),
        .o_pb_mosi(pb_mosi), .i_pb_miso(pb_miso),
        .i_isolated_mode_select(iso), .i_conv_busy(busy), .o_conv_start(conv),
        .i_rd_data(rd_data), .o_wr_data(wr_data), .o_wr_valid(wr_valid));
    dccp_upper_model up (.i_sck(pb_sck), .i_cs_n(pb_cs_n), .i_busy(up_busy), .o_miso(pb_miso));

    // Pulse monitor and hang guard, off the launching edge
    always @(negedge i_sys_clk)
    begin
        cycles++;
        if (conv === 1'b1)
            starts++;
        if (wr_valid === 1'b1)
        begin
            wrs++;
            wr_got = wr_data;
        end
        if (cycles == 40000)
        begin
            failures++;
            summarize();
        end
    end

    ////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Serial error code, MSB first with a zero appended
    function automatic logic [15:0] pec_of(input logic [47:0] d, input int n);
        logic [14:0] c;
        c = PEC_SEED;
        for (int i = n - 1; i >= 0; i--)
            c = {c[13:0], 1'b0} ^ ((d[i] ^ c[14]) ? PEC_POLY : 15'h0000);
        return {c, 1'b0};
    endfunction

    function automatic logic [31:0] cmd(input logic [10:0] code);
        return {5'h00, code, pec_of({37'h0, code}, 16)};
    endfunction

    // Link clock only runs inside frames; data set while it is low
    task automatic shift(input logic [159:0] v, input int n);
        for (int k = n - 1; k >= 0; k--)
        begin
            mosi <= v[k];
            // Rising edge kept off the system clock edges, as the clocks are unrelated
            #14;
            rx = {rx[158:0], miso};
            rxp = {rxp[158:0], pb_mosi};
            sck <= 1'b1;
            #5;
            tx_seen = txp;
            #11;
            sck <= 1'b0;
        end
    endtask

    task automatic open_cs;
        cs_n <= 1'b0;
        #20;
    endtask

    task automatic close_cs;
        #15;
        cs_n <= 1'b1;
        #40;
    endtask

    ////////////////////////////////////////
    task automatic t_rd;
        @(posedge i_sys_clk) rd_data <= 48'h1234_5678_9abc;
        open_cs();
        shift({cmd(11'h002), 96'h0}, 128);
        close_cs();
        chk(rx[95:32], {rd_data, pec_of(rd_data, 48)});
        chk(rx[31:0], 32'h7fff_ffff);
        chk(tx_seen, 1'b0);
    endtask

    // Far payload first, own payload last; bad code must be dropped
    task automatic t_wr(input logic bad);
        logic [47:0] d;
        int w;
        d = 48'hcafe_0123_4567;
        w = wrs;
        open_cs();
        shift({cmd(11'h001), 64'h5a5a_5a5a_5a5a_0000, d, pec_of(d, 48) ^ {14'h0, bad, 1'b0}}, 160);
        close_cs();
        repeat (20) @(posedge i_sys_clk);
        chk(64'(wrs - w), bad ? 64'h0 : 64'h1);
        chk(rxp[63:0], 64'h5a5a_5a5a_5a5a_0000);
        if (!bad)
            chk(wr_got, d);
    endtask

    task automatic t_badcmd;
        int s;
        s = starts;
        for (int i = 0; i < 2; i++)
        begin
            open_cs();
            // First: high byte bit set under a valid code; second: bad error code
            shift(i ? cmd(11'h260) ^ 32'h0000_0002 : {16'h8260, pec_of(48'h8260, 16)}, 32);
            shift(160'h0, 8);
            chk(rx[7:0], 8'hff);
            close_cs();
        end
        repeat (10) @(posedge i_sys_clk);
        chk(64'(starts - s), 64'h0);
    endtask

    task automatic t_conv;
        int s;
        s = starts;
        @(posedge i_sys_clk)
        begin
            busy <= 1'b1;
            up_busy <= 1'b1;
        end
        open_cs();
        shift(cmd(11'h260), 32);
        shift(160'h0, 8);
        @(posedge i_sys_clk) busy <= 1'b0;
        shift(160'h0, 8);
        chk(rx[0], 1'b0);
        @(posedge i_sys_clk) up_busy <= 1'b0;
        shift(160'h0, 8);
        chk(rx[0], 1'b1);
        @(posedge i_sys_clk) busy <= 1'b1;
        shift(160'h0, 8);
        chk(rx[0], 1'b0);
        close_cs();
        chk(miso, 1'b1);
        chk(64'(starts - s), 64'h1);
    endtask

    task automatic t_poll_conversion_status;
        @(posedge i_sys_clk) busy <= 1'b0;
        open_cs();
        shift(cmd(CODE_POLL), 32);
        shift(160'h0, 3);
        chk(rx[2:0], 3'b001);
        @(posedge i_sys_clk) busy <= 1'b1;
        shift(160'h0, 8);
        chk(rx[0], 1'b0);
        @(posedge i_sys_clk) busy <= 1'b0;
        shift(160'h0, 8);
        chk(rx[0], 1'b1);
        close_cs();
    endtask

    task automatic t_iso;
        @(posedge i_sys_clk)
        begin
            iso <= 1'b1;
            busy <= 1'b1;
        end
        open_cs();
        shift(cmd(CODE_POLL), 32);
        shift(160'h0, 8);
        chk({tx_seen, rx[0]}, 2'b10);
        @(posedge i_sys_clk) busy <= 1'b0;
        shift(160'h0, 8);
        chk({tx_seen, rx[0]}, 2'b11);
        close_cs();
        chk({txp, miso}, 2'b01);
    endtask

    ////////////////////////////////////////
    initial
    begin
        repeat (10) @(posedge i_sys_clk);
        #1;
        chk({miso, conv, wr_valid, txp, wr_data}, {4'b1000, 48'h0});
        repeat (10) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        t_rd();
        t_wr(1'b0);
        t_wr(1'b1);
        t_badcmd();
        t_conv();
        t_poll_conversion_status();
        t_iso();
        summarize();
    end
endmodule
